// File: design/pfb_bridge.sv
// host-to-parallel-flash bridge: window decode, byte sequencing, target answers
`timescale 1ns/10ps
module pfb_bridge
    import pfb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host transaction, one data phase, held until stop_b seen
    input pfb_req_t hostReq,
    output logic trdy_b,
    output logic stop_b,
    output logic devsel_b,
    output logic [31:0] rdData,
    // configuration space access
    input wire logic cfgWr,
    input wire logic cfgRd,
    input wire logic [7:0] cfgOffset,
    input wire logic [31:0] cfgWdata,
    output logic [31:0] cfgRdData,
    // size code from EEPROM load
    input wire logic eeSizeLoad,
    input wire logic [1:0] eeSizeCode,
    // strobe width in cycles, clamped to the least access time
    input wire logic [7:0] strobeCycles,
    // flash pins
    output logic [PFB_FLASH_AW-1:0] flashAddr,
    output logic [7:0] flashDataOut,
    output logic flashDataOe,
    input wire logic [7:0] flashDataIn,
    output logic flashCe_b,
    output logic flashOe_b,
    output logic flashWe_b
);

    pfb_state_t state_reg;
    pfb_state_t state_next;
    logic timerLoad;
    logic timerExpired;
    logic [7:0] timerValue;
    logic [31:0] sizeMask;
    logic memHit;
    logic ioHit;
    logic romHit;
    logic isRead;
    logic isWrite;

    // ========================================================================
    // helpers

    // lowest active lane of a byte-enable set
    function automatic logic [1:0] firstLane(input logic [3:0] be);
        logic [1:0] l;
        l = 2'h0;
        if (be[3]) l = 2'h3;
        if (be[2]) l = 2'h2;
        if (be[1]) l = 2'h1;
        if (be[0]) l = 2'h0;
        return l;
    endfunction

    // flash byte address of a lane, wrapped to the fitted size
    function automatic logic [PFB_FLASH_AW-1:0] laneAddr(input logic [31:0] a, input logic [1:0] l,
                                                        input logic [31:0] m);
        logic [31:0] full;
        full = {a[31:2], l} & ~m;
        return full[PFB_FLASH_AW-1:0];
    endfunction

    // ========================================================================
    // strobe timer

    assign timerValue = ((strobeCycles > PFB_ACCESS_CYC) ? strobeCycles : PFB_ACCESS_CYC) - 8'h01;

    pfb_cycle_timer u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .load(timerLoad),
        .loadValue(timerValue),
        .expired(timerExpired)
    );

    // ========================================================================
    // window decode

    // window size follows the size code
    assign sizeMask = ~((PFB_SMALLEST_SIZE << state_reg.sizeCode) - 32'h1);
    assign isRead = (hostReq.cmd == PFB_CMD_MEM_RD) || (hostReq.cmd == PFB_CMD_IO_RD);
    assign isWrite = (hostReq.cmd == PFB_CMD_MEM_WR) || (hostReq.cmd == PFB_CMD_IO_WR);
    assign memHit = ((hostReq.cmd == PFB_CMD_MEM_RD) || (hostReq.cmd == PFB_CMD_MEM_WR))
                    && ((hostReq.addr & sizeMask) == (state_reg.flashBase & sizeMask));
    assign ioHit = ((hostReq.cmd == PFB_CMD_IO_RD) || (hostReq.cmd == PFB_CMD_IO_WR))
                   && ((hostReq.addr & sizeMask) == (state_reg.ioBase & sizeMask));
    // boot ROM window, only while enabled
    assign romHit = (hostReq.cmd == PFB_CMD_MEM_RD) && ((state_reg.romBase & PFB_ROM_ENABLE_BIT) != 32'h0)
                    && ((hostReq.addr & sizeMask) == (state_reg.romBase & sizeMask));

    // ========================================================================
    // next state
    always_comb begin
        state_next = state_reg;
        timerLoad = 1'b0;
        // answer strobes last one cycle
        state_next.trdy_b = 1'b1;
        state_next.stop_b = 1'b1;
        state_next.devsel_b = 1'b1;
        state_next.guard = 1'b0;

        // flash data pins: three flops, accept once the last two agree
        state_next.syncA = flashDataIn;
        state_next.syncB = state_reg.syncA;
        state_next.syncC = state_reg.syncB;
        if (state_reg.syncB == state_reg.syncC) begin
            state_next.dataIn = state_reg.syncC;
        end

        // configuration space writes
        if (cfgWr) begin
            unique case (cfgOffset)
                PFB_OFF_FLASH_BASE: state_next.flashBase = cfgWdata & sizeMask;
                PFB_OFF_IO_BASE: state_next.ioBase = cfgWdata & sizeMask;
                // expansion ROM base with its enable
                PFB_OFF_ROM_BASE: state_next.romBase = cfgWdata & (sizeMask | PFB_ROM_ENABLE_BIT);
                default: ;
            endcase
        end
        // configuration space reads; unmapped offsets read zero
        if (cfgRd) begin
            unique case (cfgOffset)
                PFB_OFF_FLASH_BASE: state_next.cfgRdData = state_reg.flashBase & sizeMask;
                PFB_OFF_IO_BASE: state_next.cfgRdData = (state_reg.ioBase & sizeMask) | PFB_IO_SPACE_BIT;
                PFB_OFF_ROM_BASE: state_next.cfgRdData = state_reg.romBase & (sizeMask | PFB_ROM_ENABLE_BIT);
                default: state_next.cfgRdData = 32'h0000_0000;
            endcase
        end
        // size code captured from the EEPROM load
        if (eeSizeLoad) begin
            state_next.sizeCode = eeSizeCode;
        end

        // host side: guard skips the cycle after an answer, while the host drops its request
        if (hostReq.valid && !state_reg.guard && (memHit || ioHit || romHit) && (isRead || isWrite)) begin
            state_next.devsel_b = 1'b0;
            if (state_reg.bootWait) begin
                // boot read holds wait states past the latency limit
                if (state_reg.seq == PFB_IDLE && !state_reg.busy) begin
                    state_next.trdy_b = 1'b0;
                    state_next.stop_b = 1'b0;
                    state_next.rdData = state_reg.rbuf;
                    state_next.bootWait = 1'b0;
                    state_next.guard = 1'b1;
                end
            end else if (state_reg.busy) begin
                // retry while the flash is occupied
                state_next.stop_b = 1'b0;
                state_next.guard = 1'b1;
            end else if (isRead && state_reg.readDone && hostReq.addr == state_reg.pendAddr
                         && hostReq.byteEn == state_reg.pendBe) begin
                state_next.trdy_b = 1'b0;
                state_next.stop_b = 1'b0;
                state_next.rdData = state_reg.rbuf;
                state_next.readDone = 1'b0;
                state_next.guard = 1'b1;
            end else if (hostReq.byteEn == 4'h0) begin
                // no lanes enabled: nothing reaches the flash
                state_next.trdy_b = 1'b0;
                state_next.stop_b = 1'b0;
                state_next.rdData = 32'h0000_0000;
                state_next.guard = 1'b1;
            end else begin
                state_next.busy = 1'b1;
                state_next.readDone = 1'b0;
                state_next.isWrite = isWrite;
                state_next.pendAddr = hostReq.addr;
                state_next.pendBe = hostReq.byteEn;
                state_next.remain = hostReq.byteEn;
                state_next.lane = firstLane(hostReq.byteEn);
                state_next.rbuf = 32'h0000_0000;
                state_next.seq = PFB_SETUP;
                if (isWrite) begin
                    // data buffered, data phase completes with disconnect
                    state_next.wbuf = hostReq.wdata;
                    state_next.trdy_b = 1'b0;
                    state_next.stop_b = 1'b0;
                    state_next.guard = 1'b1;
                end else if (romHit) begin
                    // boot shadow read waits in place instead of retrying
                    state_next.bootWait = 1'b1;
                end else begin
                    // delayed read: retry now, data on a later attempt
                    state_next.stop_b = 1'b0;
                    state_next.guard = 1'b1;
                end
            end
        end

        // flash byte sequencer
        unique case (state_reg.seq)
            PFB_IDLE: ;
            PFB_SETUP: begin
                // offset plus lane on nineteen lines; wrap to size
                state_next.flash.addr = laneAddr(state_reg.pendAddr, state_reg.lane, sizeMask);
                // one byte lane on the flash data bus
                state_next.flash.dout = state_reg.wbuf[{state_reg.lane, 3'h0} +: PFB_BYTE_W];
                state_next.flash.doe = state_reg.isWrite;
                state_next.flash.ce_b = 1'b0;
                state_next.flash.oe_b = state_reg.isWrite;
                state_next.flash.we_b = !state_reg.isWrite;
                timerLoad = 1'b1;
                state_next.seq = PFB_STROBE;
            end
            PFB_STROBE: begin
                // strobe held until the counter runs out
                if (timerExpired) begin
                    state_next.flash.oe_b = 1'b1;
                    state_next.flash.we_b = 1'b1;
                    if (!state_reg.isWrite) begin
                        // gather the byte into its lane
                        state_next.rbuf[{state_reg.lane, 3'h0} +: PFB_BYTE_W] = state_reg.dataIn;
                    end
                    state_next.seq = PFB_HOLD;
                end
            end
            PFB_HOLD: begin
                // move on to the next enabled lane
                state_next.remain[state_reg.lane] = 1'b0;
                state_next.lane = firstLane(state_next.remain);
                if (state_next.remain != 4'h0) begin
                    state_next.seq = PFB_SETUP;
                end else begin
                    state_next.flash.ce_b = 1'b1;
                    state_next.flash.doe = 1'b0;
                    state_next.busy = 1'b0;
                    state_next.readDone = !state_reg.isWrite && !state_reg.bootWait;
                    state_next.seq = PFB_IDLE;
                end
            end
        endcase
    end

    // ========================================================================
    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.seq <= PFB_IDLE;
            state_reg.sizeCode <= PFB_SIZE_RESET;
            state_reg.flashBase <= PFB_BASE_RESET;
            state_reg.ioBase <= PFB_BASE_RESET;
            state_reg.romBase <= PFB_BASE_RESET;
            state_reg.flash.ce_b <= 1'b1;
            state_reg.flash.oe_b <= 1'b1;
            state_reg.flash.we_b <= 1'b1;
            state_reg.trdy_b <= 1'b1;
            state_reg.stop_b <= 1'b1;
            state_reg.devsel_b <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign trdy_b = state_reg.trdy_b;
    assign stop_b = state_reg.stop_b;
    assign devsel_b = state_reg.devsel_b;
    assign rdData = state_reg.rdData;
    assign cfgRdData = state_reg.cfgRdData;
    assign flashAddr = state_reg.flash.addr;
    assign flashDataOut = state_reg.flash.dout;
    assign flashDataOe = state_reg.flash.doe;
    assign flashCe_b = state_reg.flash.ce_b;
    assign flashOe_b = state_reg.flash.oe_b;
    assign flashWe_b = state_reg.flash.we_b;

endmodule

// File: design/pfb_pkg.sv
// shared constants and types of the parallel flash bridge
package pfb_pkg;

    // ========================================================================
    // configuration space offsets
    localparam logic [7:0] PFB_OFF_FLASH_BASE = 8'h14;
    localparam logic [7:0] PFB_OFF_IO_BASE = 8'h18;
    localparam logic [7:0] PFB_OFF_ROM_BASE = 8'h30;

    // ========================================================================
    // field layout and reset values
    localparam int PFB_FLASH_AW = 19;               // 512 KB byte address
    localparam int PFB_BYTE_W = 8;
    localparam logic [31:0] PFB_SMALLEST_SIZE = 32'h0001_0000;   // size code 0 = 64 KB
    localparam logic [1:0] PFB_SIZE_RESET = 2'h3;   // 512 KB until the EEPROM says otherwise
    localparam logic [31:0] PFB_IO_SPACE_BIT = 32'h0000_0001;
    localparam logic [31:0] PFB_ROM_ENABLE_BIT = 32'h0000_0001;
    localparam logic [31:0] PFB_BASE_RESET = 32'h0000_0000;

    // ========================================================================
    // bus commands (command/byte-enable code during the address phase)
    localparam logic [3:0] PFB_CMD_IO_RD = 4'h2;
    localparam logic [3:0] PFB_CMD_IO_WR = 4'h3;
    localparam logic [3:0] PFB_CMD_MEM_RD = 4'h6;
    localparam logic [3:0] PFB_CMD_MEM_WR = 4'h7;

    // ========================================================================
    // timing: 20 MHz clock, least access time rounds up
    localparam int PFB_CLK_PERIOD_NS = 50;
    localparam int PFB_BYTE_READ_NS = 256;
    localparam int PFB_ACCESS_CYC_INT = (PFB_BYTE_READ_NS + PFB_CLK_PERIOD_NS - 1) / PFB_CLK_PERIOD_NS;
    localparam logic [7:0] PFB_ACCESS_CYC = PFB_ACCESS_CYC_INT[7:0];

    // ========================================================================
    // byte sequencer, Gray coded along idle-setup-strobe-hold
    typedef enum logic [1:0] {
        PFB_IDLE = 2'b00,
        PFB_SETUP = 2'b01,
        PFB_STROBE = 2'b11,
        PFB_HOLD = 2'b10
    } pfb_seq_t;

    // host request carrier
    typedef struct packed {
        logic valid;
        logic [3:0] cmd;
        logic [31:0] addr;
        logic [3:0] byteEn;     // active high lanes
        logic [31:0] wdata;
    } pfb_req_t;

    // flash pin carrier
    typedef struct packed {
        logic [PFB_FLASH_AW-1:0] addr;
        logic [7:0] dout;
        logic doe;
        logic ce_b;
        logic oe_b;
        logic we_b;
    } pfb_flash_t;

    // whole state of the bridge
    typedef struct packed {
        pfb_seq_t seq;
        logic [1:0] lane;
        logic [3:0] remain;
        logic isWrite;
        logic bootWait;
        logic busy;
        logic readDone;
        logic guard;
        logic [31:0] pendAddr;
        logic [3:0] pendBe;
        logic [31:0] wbuf;
        logic [31:0] rbuf;
        logic [31:0] flashBase;
        logic [31:0] ioBase;
        logic [31:0] romBase;
        logic [1:0] sizeCode;
        logic [31:0] cfgRdData;
        logic [7:0] syncA;
        logic [7:0] syncB;
        logic [7:0] syncC;
        logic [7:0] dataIn;
        pfb_flash_t flash;
        logic trdy_b;
        logic stop_b;
        logic devsel_b;
        logic [31:0] rdData;
    } pfb_state_t;

endpackage

// File: design/pfb_cycle_timer.sv
// down counter that times one flash strobe in clock cycles
`timescale 1ns/10ps
module pfb_cycle_timer
    import pfb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // control
    input wire logic load,
    input wire logic [7:0] loadValue,
    // status
    output logic expired
);

    typedef struct packed {
        logic [7:0] count;
    } pfb_timer_t;

    pfb_timer_t timer_reg;
    pfb_timer_t timer_next;

    // reload wins over counting; stops at zero
    always_comb begin
        timer_next = timer_reg;
        if (load) begin
            timer_next.count = loadValue;
        end else if (timer_reg.count != 8'h00) begin
            timer_next.count = timer_reg.count - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_reg <= '0;
        end else begin
            timer_reg <= timer_next;
        end
    end

    assign expired = (timer_reg.count == 8'h00) && !load;

endmodule

// File: verif/pfb_bridge_checker.sv
// concurrent checks on the flash bridge ports
`timescale 1ns/10ps
module pfb_bridge_checker
    import pfb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // host side
    input pfb_req_t hostReq,
    input wire logic trdy_b,
    input wire logic stop_b,
    input wire logic devsel_b,
    // configuration and sizing
    input wire logic cfgRd,
    input wire logic [7:0] cfgOffset,
    input wire logic [31:0] cfgRdData,
    input wire logic eeSizeLoad,
    input wire logic [1:0] eeSizeCode,
    // flash pins
    input wire logic [PFB_FLASH_AW-1:0] flashAddr,
    input wire logic flashDataOe,
    input wire logic flashCe_b,
    input wire logic flashOe_b,
    input wire logic flashWe_b
);
    // =====
    // size code as last loaded, so the wrap check follows it
    logic [1:0] sizeReg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sizeReg <= PFB_SIZE_RESET;
        end else if (eeSizeLoad) begin
            sizeReg <= eeSizeCode;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // strobes never shorter than the least access time
    sequence weStrobe; !flashWe_b [*6]; endsequence
    sequence oeStrobe; !flashOe_b [*6]; endsequence
    // =====
    // completion carries disconnect
    trdy_disconnect_a: assert property (!trdy_b |-> !stop_b)
        else $error("trdy low without stop");
    answer_pulse_a: assert property (!stop_b |=> stop_b && trdy_b)
        else $error("answer longer than one cycle");
    // answers only to a seen request
    answer_cause_a: assert property (!stop_b |-> $past(hostReq.valid) && !devsel_b)
        else $error("answer without a decoded request");
    we_width_a: assert property ($fell(flashWe_b) |-> weStrobe)
        else $error("write strobe too short");
    oe_width_a: assert property ($fell(flashOe_b) |-> oeStrobe)
        else $error("read strobe too short");
    write_drive_a: assert property (!flashWe_b |-> !flashCe_b && flashOe_b && flashDataOe)
        else $error("write strobe without drive or select");
    read_float_a: assert property (!flashOe_b |-> !flashCe_b && !flashDataOe)
        else $error("read strobe while driving data");
    addr_stable_a: assert property ($fell(flashWe_b) || $fell(flashOe_b) |=> $stable(flashAddr) [*5])
        else $error("flash address moved in strobe");
    addr_wrap_a: assert property (!flashCe_b |-> (flashAddr >> (16 + sizeReg)) == 0)
        else $error("flash address beyond fitted size");
    // I/O base reads as I/O space
    io_space_bit_a: assert property (cfgRd && cfgOffset == PFB_OFF_IO_BASE |=> cfgRdData[0])
        else $error("I/O base read without space bit");
endmodule

bind pfb_bridge pfb_bridge_checker chk_u (.clk, .rst_b, .hostReq, .trdy_b, .stop_b, .devsel_b, .cfgRd,
    .cfgOffset, .cfgRdData, .eeSizeLoad, .eeSizeCode, .flashAddr, .flashDataOe, .flashCe_b, .flashOe_b,
    .flashWe_b);

// File: verif/pfb_flash_model.sv
// behavioural byte-wide flash part with adjustable access time
`timescale 1ns/10ps
module pfb_flash_model
    import pfb_pkg::*;
(
    // pins from the bridge
    input wire logic [PFB_FLASH_AW-1:0] flashAddr,
    input wire logic [7:0] flashDataOut,
    input wire logic flashCe_b,
    input wire logic flashOe_b,
    input wire logic flashWe_b,
    // access time in ns
    input wire logic [9:0] accNs,
    // data back to the bridge
    output logic [7:0] flashDataIn
);
    logic [7:0] mem [0:(1 << PFB_FLASH_AW) - 1];
    logic [7:0] lastQ;
    // known fill so reads have predictable contents
    initial begin
        lastQ = 8'h00;
        flashDataIn = 8'hFF;
        for (int i = 0; i < (1 << PFB_FLASH_AW); i++) mem[i] = i[7:0] ^ 8'h5A;
    end
    // bytes stored as they come, command decode is software's job
    always @(posedge flashWe_b) begin
        if (!flashCe_b) mem[flashAddr] = flashDataOut;
    end
    // byte read after access time; inverted junk otherwise, no pull on the bus
    always @(flashCe_b or flashOe_b or flashAddr) begin
        flashDataIn = ~lastQ;
        if (!flashCe_b && !flashOe_b) begin
            #(accNs);
            if (!flashCe_b && !flashOe_b) begin
                flashDataIn = mem[flashAddr];
                lastQ = flashDataIn;
            end
        end
    end
endmodule

// File: verif/test_parallel_flash_bridge.sv
// self-checking bench for the parallel flash bridge
`timescale 1ns/10ps
module test_parallel_flash_bridge import pfb_pkg::*;;
    logic clk, rst_b, cfgWr, cfgRd, eeSizeLoad, trdy_b, stop_b, devsel_b;
    logic flashDataOe, flashCe_b, flashOe_b, flashWe_b;
    pfb_req_t hostReq;
    logic [7:0] cfgOffset, strobeCycles, flashDataOut, flashDataIn;
    logic [31:0] cfgWdata, cfgRdData, rdData, rd, m;
    logic [1:0] eeSizeCode;
    logic [PFB_FLASH_AW-1:0] flashAddr;
    logic [9:0] accNs;
    int error_cnt = 0;
    int tests_run = 0;
    int rt, wt;
    localparam logic [31:0] FB = 32'h4000_0000, IOB = 32'h0008_0000, RB = 32'h8000_0000;
    localparam logic [7:0] OFFS [3] = '{PFB_OFF_FLASH_BASE, PFB_OFF_IO_BASE, PFB_OFF_ROM_BASE};

    pfb_bridge dut_u (.clk, .rst_b, .hostReq, .trdy_b, .stop_b, .devsel_b, .rdData, .cfgWr, .cfgRd,
        .cfgOffset, .cfgWdata, .cfgRdData, .eeSizeLoad, .eeSizeCode, .strobeCycles, .flashAddr,
        .flashDataOut, .flashDataOe, .flashDataIn, .flashCe_b, .flashOe_b, .flashWe_b);
    pfb_flash_model flash_u (.flashAddr, .flashDataOut, .flashCe_b, .flashOe_b, .flashWe_b, .accNs,
        .flashDataIn);

    // free running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // =====
    // shared tasks
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo();
        error_cnt++;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up();
    endtask
    function automatic logic [31:0] expRd(input logic [31:0] fa, input logic [3:0] be);
        logic [31:0] v;
        v = 32'h0;
        for (int n = 0; n < 4; n++) if (be[n]) v[8*n+:8] = (fa[7:0] + 8'(n)) ^ 8'h5A;
        return v;
    endfunction
    // one config access; reads are checked the cycle after the strobe
    task automatic cfgAcc(input logic wr, input logic [7:0] off, input logic [31:0] d, input logic [31:0] exp);
        @(posedge clk);
        #1;
        cfgWr = wr;
        cfgRd = !wr;
        cfgOffset = off;
        cfgWdata = d;
        @(posedge clk);
        #1;
        cfgWr = 1'b0;
        cfgRd = 1'b0;
        if (!wr) cmp(cfgRdData, exp);
    endtask
    task automatic eeLoad(input logic [1:0] code);
        @(posedge clk);
        #1;
        eeSizeLoad = 1'b1;
        eeSizeCode = code;
        @(posedge clk);
        #1;
        eeSizeLoad = 1'b0;
    endtask
    // single data phase; retries re-presented two cycles later
    task automatic hostAcc(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be, input logic [31:0] wd);
        bit done;
        done = 1'b0;
        rt = 0;
        wt = 0;
        @(posedge clk);
        #1;
        hostReq = '{1'b1, cmd, a, be, wd};
        for (int n = 0; n < 3000 && !done; n++) begin
            @(posedge clk);
            #1;
            if (stop_b === 1'b0) begin
                hostReq.valid = 1'b0;
                if (trdy_b === 1'b0) begin
                    rd = rdData;
                    done = 1'b1;
                end else begin
                    rt++;
                    repeat (2) @(posedge clk);
                    #1;
                    hostReq.valid = 1'b1;
                end
            end else wt++;
        end
        if (!done) tmo();
    endtask
    // wait until the flash cycle has started and released chip select
    task automatic waitIdle();
        int n;
        repeat (3) @(posedge clk);
        #1;
        // look off the edge so the registered select has settled
        for (n = 0; n < 500 && flashCe_b !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (n == 500) tmo();
    endtask

    // =====
    // main sequence
    initial begin
        rst_b = 1'b0;
        hostReq = '0;
        {cfgWr, cfgRd, eeSizeLoad} = 3'h0;
        {cfgOffset, cfgWdata, eeSizeCode} = 42'h0;
        strobeCycles = 8'h03;
        accNs = 10'd80;
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        cfgAcc(1'b0, PFB_OFF_FLASH_BASE, 32'h0, 32'h0);
        cfgAcc(1'b0, PFB_OFF_IO_BASE, 32'h0, PFB_IO_SPACE_BIT);
        cfgAcc(1'b0, PFB_OFF_ROM_BASE, 32'h0, 32'h0);
        // every size code resizes all three base registers
        for (int k = 0; k < 4; k++) begin
            eeLoad(2'(k));
            m = ~((PFB_SMALLEST_SIZE << k) - 32'h1);
            foreach (OFFS[j]) begin
                cfgAcc(1'b1, OFFS[j], 32'hFFFF_FFFF, 32'h0);
                cfgAcc(1'b0, OFFS[j], 32'h0, m | {31'h0, j != 0});
            end
        end
        cfgAcc(1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0);
        cfgAcc(1'b0, 8'h20, 32'h0, 32'h0);
        cfgAcc(1'b1, PFB_OFF_FLASH_BASE, FB, 32'h0);
        cfgAcc(1'b1, PFB_OFF_IO_BASE, IOB, 32'h0);
        cfgAcc(1'b1, PFB_OFF_ROM_BASE, RB | PFB_ROM_ENABLE_BIT, 32'h0);
        // single lane write answered at once, strobe width raised to the minimum
        hostAcc(PFB_CMD_MEM_WR, FB + 32'h1234, 4'h4, 32'h00AB_0000);
        cmp({31'h0, rt == 0}, 32'h1);
        waitIdle();
        cmp({24'h0, flash_u.mem[19'h1236]}, 32'hAB);
        // word write through I/O space splits into four bytes
        hostAcc(PFB_CMD_IO_WR, IOB + 32'h2000, 4'hF, 32'hA1B2_C3D4);
        waitIdle();
        for (int n = 0; n < 4; n++) begin
            cmp({24'h0, flash_u.mem[19'h2000 + n]}, (32'hA1B2_C3D4 >> (8 * n)) & 32'hFF);
        end
        hostAcc(PFB_CMD_MEM_RD, FB + 32'h2000, 4'hF, 32'h0);
        cmp(rd, 32'hA1B2_C3D4);
        cmp({31'h0, rt > 0}, 32'h1);
        // past setup, host accesses stay narrower than a word, except the full-word boot window read and the full-word miss past the window
        // slow part, longer strobes
        strobeCycles = 8'h0A;
        accNs = 10'd250;
        hostAcc(PFB_CMD_IO_RD, IOB + 32'h30, 4'hA, 32'h0);
        cmp(rd, expRd(32'h30, 4'hA));
        hostAcc(PFB_CMD_MEM_RD, FB + 32'h40, 4'h0, 32'h0);
        cmp(rd, 32'h0);
        // boot window waits instead of retrying
        hostAcc(PFB_CMD_MEM_RD, RB + 32'h7_FFFC, 4'hF, 32'h0);
        cmp(rd, expRd(32'h7_FFFC, 4'hF));
        cmp({31'h0, rt == 0 && wt > 25}, 32'h1);
        // smaller part: top byte inside the window, next address outside
        eeLoad(2'h1);
        hostAcc(PFB_CMD_MEM_RD, FB + 32'h1_FFFC, 4'h8, 32'h0);
        cmp(rd, expRd(32'h1_FFFC, 4'h8));
        @(posedge clk);
        #1;
        hostReq = '{1'b1, PFB_CMD_MEM_RD, FB + 32'h2_0000, 4'hF, 32'h0};
        repeat (8) begin
            @(posedge clk);
            #1;
            cmp({30'h0, devsel_b, stop_b}, 32'h3);
        end
        hostReq.valid = 1'b0;
        wrap_up();
    end
endmodule
